// ### rpmc_top.sv
// Top: ring PLL misc control register, shadowing, strap override, unlock interrupt
//
// Contract
// RL1: Strap override set takes input mode, clock select, table select from register.
// RL2: Unlock flag sets on lock loss, survives relock, clears on write of 1.
// RL3: Written configuration waits in shadow until next soft reset assertion.
// RL4: Writing force bit 1 latches shadow at once; hardware clears the bit.
// RL5: Lock override set reports the PLL locked regardless of detector.
// RL6: Output frequency source 1 uses internal table, 0 register selections.
// RL7: Divider table select 1 uses internal table; only under strap override.
// RL8: Reference select codes 36, 40, 25, 125 MHz; else crystal strap.
// RL9: Input mode 0 CML, 1 CMOS; without strap override always 0.
// RL10: Mode field encodes test, three host modes, PHY PLL, wireless.
// RL11: Force power-up 1 powers all divider chains, else mode table.
// RL12: Power-good override 1 disables internal regulator power-good check.
// RL13: Bias select 1 external bias current, 0 internal.
// RL14: Buffer supply select 1 external 1.1 V, 0 internal regulator.
// RL15: Mode codes 110 and 111 are reserved; behaviour undefined.
module rpmc_top (
    input  wire logic        i_mclk,           // Clock, 25 MHz
    input  wire logic        i_sys_rst,        // Async reset, high
    input  wire logic [1:0]  i_addr,           // Register word address
    input  wire logic [15:0] i_wdata,          // Write data
    input  wire logic        i_wr,             // Write strobe
    input  wire logic        i_rd,             // Read strobe
    output logic      [15:0] o_rdata,          // Read data, cycle after read
    input  wire logic        i_soft_reset_n,   // Soft reset, low
    input  wire logic [1:0]  i_crystal_strap,  // Strapped ref clock select
    input  wire logic        i_strap_divtab,   // Strapped divider table select
    input  wire logic        i_pll_lock,       // Lock detector
    output logic             o_lock,           // Reported lock
    output logic             o_strap_override, // Effective strap override
    output logic             o_in_mode_cmos,   // 1 CMOS, 0 CML input
    output logic      [1:0]  o_ref_clock_sel,  // Effective ref clock code
    output logic             o_divtab_int,     // Divider values from table
    output logic             o_ofreq_int,      // Output freqs from table
    output logic             o_force_pup,      // All divider chains up
    output logic             o_pgood_check_en, // Power-good check active
    output logic             o_bias_ext,       // External bias current
    output logic             o_buf_supply_ext, // External buffer supply
    output logic      [2:0]  o_pll_mode,       // PLL mode code
    output logic             o_irq             // Interrupt, level
);
    //////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [15:0]            misc;
        logic [rpmc_pkg::N_EVT-1:0] mask;
        logic [15:0]            rdata;
        logic                   srst_n_d;
        logic                   lock_d;
        logic                   force_ld;
        logic [1:0]             ref_sel;
        logic                   divtab;
        logic                   inmode;
        logic                   so;
        logic [2:0]             mode;
        logic [5:0]             misc_out;
    } rpmc_top_t;
    rpmc_top_t st_reg;
    rpmc_top_t st_next;

    logic [15:0]               eff_cfg;
    logic [rpmc_pkg::N_EVT-1:0] evt_set;
    logic [rpmc_pkg::N_EVT-1:0] evt_clr;
    logic [rpmc_pkg::N_EVT-1:0] evt_flag;
    logic                      unlock_set;
    logic                      unlock_clr;
    logic                      unlock_flag;
    logic                      srst_fall;
    logic                      latch_now;
    logic                      wr_misc;

    //////////////////////////////////////////////////////////////////////////////
    // Event sources
    assign wr_misc    = i_wr && (i_addr == rpmc_pkg::ADDR_MISC);
    assign unlock_set = st_reg.lock_d & ~i_pll_lock;                    // see RL2
    assign unlock_clr = wr_misc & i_wdata[rpmc_pkg::B_UNLOCK];          // see RL2
    assign srst_fall  = st_reg.srst_n_d & ~i_soft_reset_n;              // see RL3
    assign latch_now  = srst_fall | st_reg.force_ld;                    // see RL3
    assign evt_set    = {latch_now, 1'b0};
    assign evt_clr    = (i_rd && i_addr == rpmc_pkg::ADDR_STATUS) ? '1 : '0;

    rpmc_sticky #(.N(1)) u_unlock (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_set     (unlock_set),
        .i_clr     (unlock_clr),
        .o_flag    (unlock_flag)
    );

    rpmc_sticky #(.N(rpmc_pkg::N_EVT)) u_irq_stat (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_set     (evt_set | {1'b0, unlock_set}),
        .i_clr     (evt_clr),
        .o_flag    (evt_flag)
    );

    rpmc_shadow #(.W(rpmc_pkg::REG_W)) u_shadow (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_load    (latch_now),                                          // see RL4
        .i_rst_val (rpmc_pkg::MISC_RESET),
        .i_d       (st_reg.misc),
        .o_q       (eff_cfg)
    );

    //////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next          = st_reg;
        st_next.srst_n_d = i_soft_reset_n;
        st_next.lock_d   = i_pll_lock;
        st_next.force_ld = 1'b0;
        // Force bit self-clears one cycle after the write
        st_next.misc[rpmc_pkg::B_FORCE] = 1'b0;                         // see RL4
        if (wr_misc) begin
            st_next.misc = i_wdata & rpmc_pkg::MISC_RW_MASK;
            st_next.force_ld = i_wdata[rpmc_pkg::B_FORCE];              // see RL4
        end
        if (i_wr && i_addr == rpmc_pkg::ADDR_MASK) begin
            st_next.mask = i_wdata[rpmc_pkg::N_EVT-1:0];
        end
        st_next.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                rpmc_pkg::ADDR_MISC: begin
                    st_next.rdata = st_reg.misc;
                    st_next.rdata[rpmc_pkg::B_UNLOCK] = unlock_flag;     // see RL2
                end
                rpmc_pkg::ADDR_STATUS: begin
                    st_next.rdata[rpmc_pkg::N_EVT-1:0] = evt_flag;
                end
                rpmc_pkg::ADDR_MASK: begin
                    st_next.rdata[rpmc_pkg::N_EVT-1:0] = st_reg.mask;
                end
                default: begin
                    st_next.rdata = 16'h0000;
                end
            endcase
        end
        // Effective strap-dependent selections
        st_next.so = eff_cfg[rpmc_pkg::B_STRAP_OVR];
        if (eff_cfg[rpmc_pkg::B_STRAP_OVR]) begin                        // see RL1
            st_next.ref_sel = eff_cfg[rpmc_pkg::B_REF_CLOCK_SELECT_HI:rpmc_pkg::B_REF_CLOCK_SELECT_LO]; // see RL8
            st_next.divtab  = eff_cfg[rpmc_pkg::B_DIVTAB_SEL];           // see RL7
            st_next.inmode  = eff_cfg[rpmc_pkg::B_IN_MODE];              // see RL9
        end else begin
            st_next.ref_sel = i_crystal_strap;                           // see RL8
            st_next.divtab  = i_strap_divtab;                            // see RL7
            st_next.inmode  = 1'b0;                                      // see RL9
        end
        // Reserved codes pass through unchanged
        st_next.mode = eff_cfg[rpmc_pkg::B_MODE_HI:rpmc_pkg::B_MODE_LO]; // see RL10 see RL15
        st_next.misc_out = {eff_cfg[rpmc_pkg::B_BUF_SUPPLY],             // see RL14
                            eff_cfg[rpmc_pkg::B_BIAS_SEL],               // see RL13
                            eff_cfg[rpmc_pkg::B_LOCK_OVR],               // see RL5
                            ~eff_cfg[rpmc_pkg::B_PGOOD_OVR],             // see RL12
                            eff_cfg[rpmc_pkg::B_OFREQ_SRC],              // see RL6
                            eff_cfg[rpmc_pkg::B_FORCE_PUP]};             // see RL11
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg          <= '0;
            st_reg.misc     <= rpmc_pkg::MISC_RESET;
            st_reg.srst_n_d <= 1'b1;
            st_reg.lock_d   <= 1'b0;
            st_reg.ref_sel  <= rpmc_pkg::REF_36MHZ;
            st_reg.mode     <= rpmc_pkg::RPMC_HOST_APP_MODE_B;
        end else begin
            st_reg <= st_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_rdata          = st_reg.rdata;
    assign o_strap_override = st_reg.so;
    assign o_ref_clock_sel  = st_reg.ref_sel;
    assign o_divtab_int     = st_reg.divtab;
    assign o_in_mode_cmos   = st_reg.inmode;
    assign o_pll_mode       = st_reg.mode;
    assign o_buf_supply_ext = st_reg.misc_out[5];
    assign o_bias_ext       = st_reg.misc_out[4];
    assign o_lock           = st_reg.lock_d | st_reg.misc_out[3];        // see RL5
    assign o_pgood_check_en = st_reg.misc_out[2];
    assign o_ofreq_int      = st_reg.misc_out[1];
    assign o_force_pup      = st_reg.misc_out[0];
    assign o_irq            = |(evt_flag & st_reg.mask);
endmodule : rpmc_top

// ### rpmc_pkg.sv
// Package: register layout, reset value and mode codes of the PLL misc control block
package rpmc_pkg;
    localparam int              REG_W          = 16;
    localparam logic [1:0]      ADDR_MISC      = 2'h0;
    localparam logic [1:0]      ADDR_STATUS    = 2'h1;
    localparam logic [1:0]      ADDR_MASK      = 2'h2;
    localparam logic [15:0]     MISC_RESET     = 16'h0022;
    localparam logic [15:0]     MISC_RW_MASK   = 16'hbfff;
    localparam int              B_STRAP_OVR    = 15;
    localparam int              B_UNLOCK       = 14;
    localparam int              B_FORCE        = 13;
    localparam int              B_BUF_SUPPLY   = 12;
    localparam int              B_BIAS_SEL     = 11;
    localparam int              B_LOCK_OVR     = 10;
    localparam int              B_PGOOD_OVR    = 9;
    localparam int              B_OFREQ_SRC    = 8;
    localparam int              B_DIVTAB_SEL   = 7;
    localparam int              B_FORCE_PUP    = 6;
    localparam int              B_REF_CLOCK_SELECT_HI    = 5;
    localparam int              B_REF_CLOCK_SELECT_LO    = 4;
    localparam int              B_IN_MODE      = 3;
    localparam int              B_MODE_HI      = 2;
    localparam int              B_MODE_LO      = 0;
    localparam int              N_EVT          = 2;
    localparam int              EV_UNLOCK      = 0;
    localparam int              EV_LATCH       = 1;
    localparam logic [1:0]      REF_36MHZ      = 2'h0;
    localparam logic [1:0]      REF_40MHZ      = 2'h1;
    localparam logic [1:0]      REF_25MHZ      = 2'h2;
    localparam logic [1:0]      REF_125MHZ     = 2'h3;
    typedef enum logic [2:0] {
        RPMC_TEST_MODE_CODE  = 3'b000,
        RPMC_HOST_APP_MODE_A = 3'b001,
        RPMC_HOST_APP_MODE_B = 3'b010,
        RPMC_HOST_APP_MODE_C = 3'b011,
        RPMC_PHY_PLL_MODE    = 3'b100,
        RPMC_WIRELESS_MODE   = 3'b101
    } rpmc_mode_t;
endpackage : rpmc_pkg

// ### rpmc_sticky.sv
// Sticky event flags with per-bit clear; a set wins over a clear
module rpmc_sticky #(
    parameter int N = 2
) (
    input  wire logic         i_mclk,    // Clock
    input  wire logic         i_sys_rst, // Async reset, high
    input  wire logic [N-1:0] i_set,     // Event pulses
    input  wire logic [N-1:0] i_clr,     // Clear pulses
    output logic      [N-1:0] o_flag     // Sticky flags
);
    typedef struct packed {
        logic [N-1:0] flag;
    } rpmc_sticky_t;
    rpmc_sticky_t st_reg;
    rpmc_sticky_t st_next;

    always_comb begin
        st_next = st_reg;
        for (int k = 0; k < N; k++) begin
            st_next.flag[k] = i_set[k] | (st_reg.flag[k] & ~i_clr[k]);
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_flag = st_reg.flag;
endmodule : rpmc_sticky

// ### rpmc_shadow.sv
// Shadow latch: holds the configuration in effect, loaded on soft reset or force
module rpmc_shadow #(
    parameter int W = 16
) (
    input  wire logic         i_mclk,    // Clock
    input  wire logic         i_sys_rst, // Async reset, high
    input  wire logic         i_load,    // Load strobe
    input  wire logic [W-1:0] i_rst_val, // Reset value, constant
    input  wire logic [W-1:0] i_d,       // Staged configuration
    output logic      [W-1:0] o_q        // Effective configuration
);
    typedef struct packed {
        logic [W-1:0] q;
        logic         loaded;
    } rpmc_shadow_t;
    rpmc_shadow_t sh_reg;
    rpmc_shadow_t sh_next;

    always_comb begin
        sh_next = sh_reg;
        if (i_load) begin
            sh_next.q      = i_d;
            sh_next.loaded = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    // Before the first load the reset value is in effect
    assign o_q = sh_reg.loaded ? sh_reg.q : i_rst_val;
endmodule : rpmc_shadow

// ### rpmc_checker.sv
// Checker: timing relations of the PLL misc control block
module rpmc_checker (
    input wire logic        i_mclk,           // Clock
    input wire logic        i_sys_rst,        // Reset
    input wire logic [1:0]  i_addr,           // Address
    input wire logic [15:0] i_wdata,          // Write data
    input wire logic        i_wr,             // Write
    input wire logic        i_rd,             // Read
    input wire logic [15:0] o_rdata,          // Read data
    input wire logic        i_soft_reset_n,   // Soft reset
    input wire logic [1:0]  i_crystal_strap,  // Strap
    input wire logic        i_pll_lock,       // Lock in
    input wire logic        o_lock,           // Lock out
    input wire logic        o_strap_override, // Override
    input wire logic [1:0]  o_ref_clock_sel,  // Ref select
    input wire logic        o_bias_ext,       // Bias
    input wire logic [2:0]  o_pll_mode        // Mode
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    logic       fw;
    logic       sr_q;
    logic       lk_q;
    logic       unl_m;
    logic [2:0] age;
    logic [1:0] run;
    assign fw = i_wr && i_addr == 2'h0 && i_wdata[13];
    ////////////////////////////////////////////////////////////////
    // Load age, unlock flag model, cycles since reset
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sr_q  <= 1'b1;
            lk_q  <= 1'b0;
            unl_m <= 1'b0;
            age   <= 3'h7;
            run   <= 2'h0;
        end else begin
            sr_q  <= i_soft_reset_n;
            lk_q  <= i_pll_lock;
            unl_m <= (lk_q && !i_pll_lock) || (unl_m && !(i_wr && i_addr == 2'h0 && i_wdata[14]));
            age   <= (fw || (sr_q && !i_soft_reset_n)) ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
            run   <= (run == 2'h3) ? run : run + 2'h1;
        end
    end
    property p_force_mode;
        logic [15:0] d;
        (fw, d = i_wdata) |-> ##4 o_pll_mode == d[2:0] && o_bias_ext == d[11];
    endproperty
    property p_ref_sel;
        logic [15:0] d;
        (fw, d = i_wdata) |-> ##4 o_strap_override == d[15] &&
            o_ref_clock_sel == (d[15] ? d[5:4] : i_crystal_strap);
    endproperty
    ////////////////////////////////////////////////////////////////
    chk_lock_pass: assert property (i_pll_lock [*3] |-> o_lock)
        else $error("lock not reported");
    chk_lock_only: assert property (run == 2'h3 && !o_lock |->
        !$past(i_pll_lock) || !$past(i_pll_lock, 2)) else $error("lock dropped wrongly");
    chk_cfg_hold: assert property (($changed(o_pll_mode) || $changed(o_bias_ext))
        |-> age <= 3'h3) else $error("config changed without load");
    chk_force_mode: assert property (p_force_mode)
        else $error("forced config not applied");
    chk_ref_select: assert property (p_ref_sel)
        else $error("ref select wrong");
    chk_force_clear: assert property (i_rd && i_addr == 2'h0 && !fw && age > 3'h2
        |=> !o_rdata[13]) else $error("force bit not cleared");
    chk_unlock_set: assert property (i_rd && i_addr == 2'h0 && unl_m && $past(unl_m)
        && $past(unl_m, 2) |=> o_rdata[14]) else $error("unlock flag missing");
    chk_unlock_clr: assert property (i_rd && i_addr == 2'h0 && !unl_m && !$past(unl_m)
        && !$past(unl_m, 2) |=> !o_rdata[14]) else $error("unlock flag spurious");
    cover property (fw);
    cover property ($fell(i_pll_lock));
    cover property (i_rd && i_addr == 2'h3);
endmodule : rpmc_checker
bind rpmc_top rpmc_checker rpmc_checker_inst (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_soft_reset_n(i_soft_reset_n),
    .i_crystal_strap(i_crystal_strap), .i_pll_lock(i_pll_lock), .o_lock(o_lock),
    .o_strap_override(o_strap_override), .o_ref_clock_sel(o_ref_clock_sel),
    .o_bias_ext(o_bias_ext), .o_pll_mode(o_pll_mode));

// ### rpmc_pll_model.sv
// Partner: lock detector and pin straps seen by the misc control block
module rpmc_pll_model #(
    parameter logic [1:0] STRAP_CLK = 2'h2, // Strapped ref clock code
    parameter logic       STRAP_TAB = 1'b1  // Strapped table select
) (
    input  wire logic       i_mclk,          // Clock
    input  wire logic       i_drop,          // Lose lock now
    output logic            o_pll_lock,      // Lock level
    output logic      [1:0] o_crystal_strap, // Strapped ref clock
    output logic            o_strap_divtab   // Strapped table select
);
    timeunit 1ns;
    timeprecision 1ns;
    int relock = 6;
    // Relock takes six cycles after a loss
    always @(posedge i_mclk) begin
        if (i_drop) begin
            relock <= 6;
        end else if (relock > 0) begin
            relock <= relock - 1;
        end
    end
    assign o_pll_lock      = (relock == 0);
    assign o_crystal_strap = STRAP_CLK;
    assign o_strap_divtab  = STRAP_TAB;
endmodule : rpmc_pll_model

// ### testbench.sv
// Testbench: random and corner checks of the PLL misc control block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [1:0]  i_addr = 2'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_soft_reset_n = 1'b1;
    logic        drop = 1'b0;
    logic [1:0]  strap;
    logic        stab, lock, o_lock, o_irq;
    logic [15:0] o_rdata, d, eff;
    wire logic [12:0] cfg;
    int          err_count = 0;
    int          total_checks = 0;
    always #20 i_mclk = ~i_mclk;
    rpmc_top rpmc_top_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_soft_reset_n(i_soft_reset_n), .i_crystal_strap(strap), .i_strap_divtab(stab),
        .i_pll_lock(lock), .o_lock(o_lock), .o_strap_override(cfg[12]),
        .o_in_mode_cmos(cfg[11]), .o_ref_clock_sel(cfg[10:9]), .o_divtab_int(cfg[8]),
        .o_ofreq_int(cfg[7]), .o_force_pup(cfg[6]), .o_pgood_check_en(cfg[5]),
        .o_bias_ext(cfg[4]), .o_buf_supply_ext(cfg[3]), .o_pll_mode(cfg[2:0]), .o_irq(o_irq));
    rpmc_pll_model rpmc_pll_model_inst (.i_mclk(i_mclk), .i_drop(drop), .o_pll_lock(lock),
        .o_crystal_strap(strap), .o_strap_divtab(stab));
    ////////////////////////////////////////////////////////////////
    function automatic logic [12:0] expv(input logic [15:0] v);
        return {v[15], v[15] & v[3], v[15] ? v[5:4] : strap, v[15] ? v[7] : stab,
                v[8], v[6], ~v[9], v[11], v[12], v[2:0]};
    endfunction : expv
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [1:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk("rdata", e & m, o_rdata & m);
    endtask : rd
    task cc(input logic [15:0] v);
        @(negedge i_mclk);
        chk("cfg", {3'h0, expv(v)}, {3'h0, cfg});
    endtask : cc
    task lose;
        @(posedge i_mclk);
        drop <= 1'b1;
        @(posedge i_mclk);
        drop <= 1'b0;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask : lose
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge i_mclk);
        err_count++;
        wrap_up();
    end
    initial begin
        d = 16'($urandom(32'h0000_a331));
        eff = 16'h0022;
        repeat (20) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(2'h0, 16'hffff, 16'h0022);
        cc(16'h0022);
        rd(2'h1, 16'hffff, 16'h0000);
        rd(2'h2, 16'hffff, 16'h0000);
        wr(2'h3, 16'hffff);
        rd(2'h3, 16'hffff, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            d = (16'($urandom) & 16'h1bc8) | {i[0], 1'b0, i[1], 7'h00, i[2:1], 1'b0, 3'(i % 6)};
            wr(2'h0, d);
            if (!d[13]) begin
                repeat (3) @(posedge i_mclk);
                cc(eff);
                @(posedge i_mclk);
                i_soft_reset_n <= 1'b0;
                repeat (2) @(posedge i_mclk);
                i_soft_reset_n <= 1'b1;
            end
            repeat (4) @(posedge i_mclk);
            cc(d);
            rd(2'h0, 16'hffff, d & 16'hdfff);
            eff = d;
        end
        wr(2'h0, 16'h2022);
        repeat (3) @(posedge i_mclk);
        rd(2'h1, 16'hffff, 16'h0002);
        wr(2'h2, 16'h0001);
        lose();
        chk("lock", 16'h0000, {15'h0000, o_lock});
        chk("irq", 16'h0001, {15'h0000, o_irq});
        repeat (8) @(posedge i_mclk);
        rd(2'h0, 16'h4000, 16'h4000);
        rd(2'h1, 16'hffff, 16'h0001);
        chk("irq", 16'h0000, {15'h0000, o_irq});
        wr(2'h0, 16'h4022);
        rd(2'h0, 16'h4000, 16'h0000);
        wr(2'h2, 16'h0002);
        lose();
        chk("irq", 16'h0000, {15'h0000, o_irq});
        repeat (8) @(posedge i_mclk);
        wr(2'h0, 16'h2422);
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        chk("irq", 16'h0001, {15'h0000, o_irq});
        lose();
        chk("lock", 16'h0001, {15'h0000, o_lock});
        repeat (8) @(posedge i_mclk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(2'h0, 16'hffff, 16'h0022);
        cc(16'h0022);
        wrap_up();
    end
endmodule : testbench
